// ===== utp_regs.sv
// Purpose: Pattern samples 5 to 7, pattern control, pattern generator
// Assumes: Port master never stalls; read data one cycle after strobe
// Notes: Samples 0 to 4 are inputs from the neighbouring register bank
// Operation
// - Sample five register holds 12 bits, resets to all ones.
// - Sample six register holds 12 bits, resets to all zeros.
// - Sample seven register holds 12 bits, resets to all ones.
// - Fixed lane bit replaces programmed samples with fixed zero/one sequence.
// - Bus inversions apply to fixed lane pattern as to user pattern.
// - Control bit 3 inverts sample bit 11 on bus D.
// - Control bit 2 inverts sample bit 10 on bus C.
// - Control bit 1 inverts sample bit 9 on bus B.
// - Control register resets to 0x1E; bits 7 to 5 read zero.
// - Control bit 0 inverts sample bit 8 on bus A.
// - With output enable low, output logic held in reset, outputs off.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module utp_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register port
  input wire logic [utp_pkg::ADDR_W-1:0] addr,
  input wire logic [utp_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [utp_pkg::DATA_W-1:0] rdata,
  // Neighbouring configuration
  input wire logic out_enable,
  input wire logic pattern_selection,
  input wire logic [5*utp_pkg::SAMP_W-1:0] low_samples,
  // Sample data path, bus A in the low slice
  input wire logic [4*utp_pkg::SAMP_W-1:0] adc_data,
  output logic [4*utp_pkg::SAMP_W-1:0] bus_data,
  output logic bus_active
);
  import utp_pkg::*;

  logic [SAMP_W-1:0] pattern_sample_five;
  logic [SAMP_W-1:0] pattern_sample_six;
  logic [SAMP_W-1:0] pattern_sample_seven;
  logic [CTL_W-1:0] pattern_control;
  logic [2:0] idx;
  logic [SAMP_W-1:0] cur;
  logic [4*SAMP_W-1:0] next_bus;
  logic gen_on;

  // Generator running this cycle, used by the checks below
  assign gen_on = out_enable && pattern_selection;

  // Register writes; reserved bits are not stored and read back as zero
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pattern_sample_five <= RST_SAMPLE_FIVE[SAMP_W-1:0];
      pattern_sample_six <= RST_SAMPLE_SIX[SAMP_W-1:0];
      pattern_sample_seven <= RST_SAMPLE_SEVEN[SAMP_W-1:0];
      pattern_control <= RST_CONTROL[CTL_W-1:0];
    end else if (wr) begin
      // Writes are taken at any time; keeping them to disabled phases
      // is the host's duty, since a live change tears the sequence
      unique case (addr)
        OFS_SAMPLE_FIVE: pattern_sample_five <= wdata[SAMP_W-1:0];
        OFS_SAMPLE_SIX: pattern_sample_six <= wdata[SAMP_W-1:0];
        OFS_SAMPLE_SEVEN: pattern_sample_seven <= wdata[SAMP_W-1:0];
        OFS_CONTROL: pattern_control <= wdata[CTL_W-1:0];
        default: ;
      endcase
    end
  end

  // Read data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata <= '0;
    end else if (rd) begin
      unique case (addr)
        OFS_SAMPLE_FIVE: rdata <= {4'h0, pattern_sample_five};
        OFS_SAMPLE_SIX: rdata <= {4'h0, pattern_sample_six};
        OFS_SAMPLE_SEVEN: rdata <= {4'h0, pattern_sample_seven};
        OFS_CONTROL: rdata <= {11'h000, pattern_control};
        default: rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end

  // Sample index walks 0..7 and wraps; held at zero while disabled
  always_ff @(posedge clk) begin
    if (!nrst || !out_enable) begin
      idx <= 3'h0;
    end else if (pattern_selection) begin
      idx <= (idx == LAST_IDX) ? 3'h0 : idx + 3'h1;
    end else begin
      idx <= 3'h0;
    end
  end

  // Current pattern sample before bus inversion
  always_comb begin
    if (pattern_control[CTL_FIXED_LANE_PATTERN]) begin
      cur = {SAMP_W{LANE_SEQ[idx]}};
    end else begin
      unique case (idx)
        3'h5: cur = pattern_sample_five;
        3'h6: cur = pattern_sample_six;
        3'h7: cur = pattern_sample_seven;
        default: cur = low_samples[idx*SAMP_W +: SAMP_W];
      endcase
    end
  end

  // Each bus n flips bit 8+n when its control bit is set, for both
  // the programmed and the fixed sequence
  always_comb begin
    next_bus = '0;
    for (int b = 0; b < NBUS; b++) begin
      if (pattern_selection) begin
        next_bus[b*SAMP_W +: SAMP_W] = cur;
        next_bus[b*SAMP_W + INV_BIT_A + b] =
          cur[INV_BIT_A + b] ^ pattern_control[CTL_INV_A + b];
      end else begin
        next_bus[b*SAMP_W +: SAMP_W] = adc_data[b*SAMP_W +: SAMP_W];
      end
    end
  end

  // Outputs are quiet zero while disabled, standing in for power-down
  always_ff @(posedge clk) begin
    if (!nrst || !out_enable) begin
      bus_data <= '0;
      bus_active <= 1'b0;
    end else begin
      bus_data <= next_bus;
      bus_active <= 1'b1;
    end
  end

  AST_CTL_RESET: assert property (@(posedge clk)
    $rose(nrst) |-> pattern_control == RST_CONTROL[CTL_W-1:0])
    else $error("control reset value wrong");

  AST_FIVE_RESET: assert property (@(posedge clk)
    $rose(nrst) |-> pattern_sample_five == 12'hFFF)
    else $error("sample five reset wrong");

  AST_SIX_RESET: assert property (@(posedge clk)
    $rose(nrst) |-> pattern_sample_six == 12'h000)
    else $error("sample six reset wrong");

  AST_SEVEN_RESET: assert property (@(posedge clk)
    $rose(nrst) |-> pattern_sample_seven == 12'hFFF)
    else $error("sample seven reset wrong");

  AST_DISABLED_QUIET: assert property (@(posedge clk) disable iff (!nrst)
    !out_enable |=> bus_data == '0 && !bus_active)
    else $error("outputs active while disabled");

  AST_INDEX_WALK: assert property (@(posedge clk) disable iff (!nrst)
    out_enable && pattern_selection && idx == LAST_IDX
    |=> idx == 3'h0)
    else $error("pattern index did not wrap");

  AST_LANE_FIXED: assert property (@(posedge clk) disable iff (!nrst)
    out_enable && pattern_selection && pattern_control[CTL_FIXED_LANE_PATTERN]
    && idx == 3'h1 |=> bus_data[7:0] == 8'hFF)
    else $error("fixed lane sample wrong on bus A");

  AST_INV_D: assert property (@(posedge clk) disable iff (!nrst)
    out_enable && pattern_selection |=>
    bus_data[3*SAMP_W+11] ==
    ($past(cur[11]) ^ $past(pattern_control[CTL_INV_D])))
    else $error("bus D bit 11 inversion wrong");

  AST_INV_B: assert property (@(posedge clk) disable iff (!nrst)
    out_enable && pattern_selection |=>
    bus_data[SAMP_W+9] ==
    ($past(cur[9]) ^ $past(pattern_control[CTL_INV_A+1])))
    else $error("bus B bit 9 inversion wrong");

  AST_INV_C: assert property (@(posedge clk)
    disable iff (!nrst)
    gen_on
    |=> bus_data[2*SAMP_W+10] == ($past(cur[10]) ^ $past(pattern_control[2])))
    else $error("bus C bit 10 inversion wrong");

  AST_INV_A: assert property (@(posedge clk)
    disable iff (!nrst)
    gen_on
    |=> bus_data[8] == ($past(cur[8]) ^ $past(pattern_control[CTL_INV_A])))
    else $error("bus A bit 8 inversion wrong");

  AST_KEEP_A: assert property (@(posedge clk)
    disable iff (!nrst)
    gen_on
    |=> bus_data[7:0] == $past(cur[7:0]) && bus_data[11:9] == $past(cur[11:9]))
    else $error("bus A untouched bits wrong");

  AST_KEEP_B: assert property (@(posedge clk)
    disable iff (!nrst)
    gen_on
    |=> bus_data[20:12] == $past(cur[8:0]) && bus_data[23:22] == $past(cur[11:10]))
    else $error("bus B untouched bits wrong");

  AST_KEEP_C: assert property (@(posedge clk)
    disable iff (!nrst)
    gen_on
    |=> bus_data[33:24] == $past(cur[9:0]) && bus_data[35] == $past(cur[11]))
    else $error("bus C untouched bits wrong");

  AST_KEEP_D: assert property (@(posedge clk)
    disable iff (!nrst)
    gen_on
    |=> bus_data[46:36] == $past(cur[10:0]))
    else $error("bus D untouched bits wrong");

  AST_PASS_THRU: assert property (@(posedge clk)
    disable iff (!nrst)
    out_enable && !pattern_selection
    |=> bus_data == $past(adc_data))
    else $error("sample data not passed through");

  AST_ACTIVE_ON: assert property (@(posedge clk)
    disable iff (!nrst)
    out_enable
    |=> bus_active)
    else $error("outputs idle while enabled");

  AST_IDX_STEP: assert property (@(posedge clk)
    disable iff (!nrst)
    gen_on && idx != LAST_IDX
    |=> idx == $past(idx) + 3'h1)
    else $error("pattern index did not step");

  AST_IDX_HOLD: assert property (@(posedge clk)
    disable iff (!nrst)
    !out_enable
    |=> idx == 3'h0)
    else $error("pattern index moved while disabled");

  AST_IDX_NOSEL: assert property (@(posedge clk)
    disable iff (!nrst)
    out_enable && !pattern_selection
    |=> idx == 3'h0)
    else $error("pattern index moved while not selected");

  AST_WR_FIVE: assert property (@(posedge clk)
    disable iff (!nrst)
    wr && addr == OFS_SAMPLE_FIVE
    |=> pattern_sample_five == $past(wdata[SAMP_W-1:0]))
    else $error("sample five write lost");

  AST_WR_SIX: assert property (@(posedge clk)
    disable iff (!nrst)
    wr && addr == OFS_SAMPLE_SIX
    |=> pattern_sample_six == $past(wdata[SAMP_W-1:0]))
    else $error("sample six write lost");

  AST_WR_SEVEN: assert property (@(posedge clk)
    disable iff (!nrst)
    wr && addr == OFS_SAMPLE_SEVEN
    |=> pattern_sample_seven == $past(wdata[SAMP_W-1:0]))
    else $error("sample seven write lost");

  AST_WR_CTL: assert property (@(posedge clk)
    disable iff (!nrst)
    wr && addr == OFS_CONTROL
    |=> pattern_control == $past(wdata[CTL_W-1:0]))
    else $error("control write lost");

  AST_KEEP_FIVE: assert property (@(posedge clk)
    disable iff (!nrst)
    !(wr && addr == OFS_SAMPLE_FIVE)
    |=> $stable(pattern_sample_five))
    else $error("sample five changed without write");

  AST_KEEP_SIX: assert property (@(posedge clk)
    disable iff (!nrst)
    !(wr && addr == OFS_SAMPLE_SIX)
    |=> $stable(pattern_sample_six))
    else $error("sample six changed without write");

  AST_KEEP_SEVEN: assert property (@(posedge clk)
    disable iff (!nrst)
    !(wr && addr == OFS_SAMPLE_SEVEN)
    |=> $stable(pattern_sample_seven))
    else $error("sample seven changed without write");

  AST_KEEP_CTL: assert property (@(posedge clk)
    disable iff (!nrst)
    !(wr && addr == OFS_CONTROL)
    |=> $stable(pattern_control))
    else $error("control changed without write");

  AST_RD_FIVE: assert property (@(posedge clk)
    disable iff (!nrst)
    rd && addr == OFS_SAMPLE_FIVE
    |=> rdata == {4'h0, $past(pattern_sample_five)})
    else $error("sample five read wrong");

  AST_RD_SIX: assert property (@(posedge clk)
    disable iff (!nrst)
    rd && addr == OFS_SAMPLE_SIX
    |=> rdata == {4'h0, $past(pattern_sample_six)})
    else $error("sample six read wrong");

  AST_RD_SEVEN: assert property (@(posedge clk)
    disable iff (!nrst)
    rd && addr == OFS_SAMPLE_SEVEN
    |=> rdata == {4'h0, $past(pattern_sample_seven)})
    else $error("sample seven read wrong");

  AST_RD_CTL: assert property (@(posedge clk)
    disable iff (!nrst)
    rd && addr == OFS_CONTROL
    |=> rdata == {11'h000, $past(pattern_control)})
    else $error("control read wrong");

  AST_RD_IDLE: assert property (@(posedge clk)
    disable iff (!nrst)
    !rd
    |=> rdata == 16'h0000)
    else $error("read data not cleared");

  AST_LANE_ZERO: assert property (@(posedge clk)
    disable iff (!nrst)
    gen_on && pattern_control[CTL_FIXED_LANE_PATTERN] && idx == 3'h0
    |=> bus_data[7:0] == 8'h00)
    else $error("fixed lane first sample wrong");

  AST_LANE_IGNORE: assert property (@(posedge clk)
    disable iff (!nrst)
    gen_on && pattern_control[CTL_FIXED_LANE_PATTERN] && idx == 3'h5
    |=> bus_data[7:0] == 8'hFF)
    else $error("fixed lane did not override sample five");

  AST_LANE_INV_D: assert property (@(posedge clk)
    disable iff (!nrst)
    gen_on && pattern_control[CTL_FIXED_LANE_PATTERN]
    |=> bus_data[47] == ($past(LANE_SEQ[idx]) ^ $past(pattern_control[CTL_INV_D])))
    else $error("fixed lane bus D inversion wrong");

  AST_USER_FIVE: assert property (@(posedge clk)
    disable iff (!nrst)
    gen_on && !pattern_control[CTL_FIXED_LANE_PATTERN] && idx == 3'h5
    |=> bus_data[7:0] == $past(pattern_sample_five[7:0]))
    else $error("sample five not emitted at index five");

  AST_USER_LOW: assert property (@(posedge clk)
    disable iff (!nrst)
    gen_on && !pattern_control[CTL_FIXED_LANE_PATTERN] && idx == 3'h0
    |=> bus_data[7:0] == $past(low_samples[7:0]))
    else $error("sample zero not emitted at index zero");
endmodule
`default_nettype wire

// ===== utp_pkg.sv
// Purpose: Constants for the user test pattern register bank
// Assumes: 16-bit register port, byte offsets as printed
// Notes: Sample 0..4 values arrive from the neighbouring bank
package utp_pkg;
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned SAMP_W = 12;
  localparam int unsigned NSAMP = 8;
  localparam int unsigned NBUS = 4;
  localparam logic [9:0] OFS_SAMPLE_FIVE = 10'h18A;
  localparam logic [9:0] OFS_SAMPLE_SIX = 10'h18C;
  localparam logic [9:0] OFS_SAMPLE_SEVEN = 10'h18E;
  localparam logic [9:0] OFS_CONTROL = 10'h190;
  localparam logic [15:0] RST_SAMPLE_FIVE = 16'h0FFF;
  localparam logic [15:0] RST_SAMPLE_SIX = 16'h0000;
  localparam logic [15:0] RST_SAMPLE_SEVEN = 16'h0FFF;
  localparam logic [7:0] RST_CONTROL = 8'h1E;
  localparam int unsigned CTL_INV_A = 0;
  localparam int unsigned CTL_INV_D = 3;
  localparam int unsigned CTL_FIXED_LANE_PATTERN = 4;
  localparam int unsigned CTL_W = 5;
  localparam int unsigned INV_BIT_A = 8;
  // Fixed lane sequence, one bit per index: 1 means all ones.
  // Only eight indices exist, so the first eight listed samples are used
  localparam logic [7:0] LANE_SEQ = 8'hE2;
  localparam logic [2:0] LAST_IDX = 3'h7;
endpackage

// ===== utp_receiver.sv
// Purpose: Receiving logic model for the four output buses
// Assumes: Captures on the rising edge while bus_active is high
// Notes: Keeps only the last word; it checks nothing itself
`timescale 1ns/1ps
`default_nettype none
module utp_receiver (
  // Clock
  input wire logic clk,
  // Output buses
  input wire logic [47:0] bus_data,
  input wire logic bus_active,
  // Captured word
  output logic [47:0] rx_word
);
  always_ff @(posedge clk) begin
    if (bus_active) begin
      rx_word <= bus_data;
    end
  end
endmodule
`default_nettype wire

// ===== testbench.sv
// Purpose: Self-checking bench for the user test pattern registers
// Assumes: 125 MHz clock, reset held for 16 cycles
// Notes: Pattern registers are written only while oe is low
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import utp_pkg::*;
  logic clk = 0, nrst = 0, wr = 0, rd = 0, oe = 0, sel = 0, act;
  logic [9:0] addr = '0;
  logic [15:0] wdata = '0, rdata;
  logic [59:0] low = 60'h123456789ABCDEF;
  logic [47:0] adc = 48'hA5C396F01E2D, bus, rx;
  logic [11:0] smp [3] = '{12'hABC, 12'h234, 12'h555};
  logic [9:0] ra [5] = '{10'h18A, 10'h18C, 10'h18E, 10'h190, 10'h192};
  logic [15:0] rw [5] = '{16'hFABC, 16'h1234, 16'hF555, 16'h00FF, 16'hFFFF};
  logic [15:0] re [5] = '{16'h0ABC, 16'h0234, 16'h0555, 16'h001F, 16'h0};
  logic [15:0] rr [4] = '{16'h0FFF, 16'h0000, 16'h0FFF, 16'h001E};
  logic [7:0] cv [3] = '{8'h00, 8'h0F, 8'h1A};
  int err_count = 0, tests_run = 0;
  always #4 clk = ~clk;
  utp_regs DUT (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .out_enable(oe),
    .pattern_selection(sel), .low_samples(low), .adc_data(adc),
    .bus_data(bus), .bus_active(act));
  utp_receiver rx_model (.clk(clk), .bus_data(bus), .bus_active(act),
    .rx_word(rx));
  task chk(string n, logic [48:0] s, logic [48:0] e);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr_reg(logic [9:0] a, logic [15:0] d);
    wr <= 1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 0;
  endtask
  task rd_reg(logic [9:0] a, logic [15:0] e);
    rd <= 1;
    addr <= a;
    @(posedge clk);
    rd <= 0;
    #1 chk("rdata", rdata, e);
  endtask
  // Fixed lane pattern ignores every sample register, inversions still apply
  function automatic logic [47:0] exp_bus(int i, logic [7:0] c);
    logic [11:0] s;
    logic [47:0] r;
    if (c[4])
      s = {12{LANE_SEQ[i]}};
    else if (i < 5)
      s = low[12*i +: 12];
    else
      s = smp[i-5];
    for (int b = 0; b < 4; b++) begin
      r[12*b +: 12] = s;
      r[12*b+8+b] = s[8+b] ^ c[b];
    end
    return r;
  endfunction
  task print_verdict;
    $display("Mismatches %0d, checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge clk);
    err_count++;
    print_verdict;
  end
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1;
    for (int k = 0; k < 5; k++) begin
      wr_reg(ra[k], rw[k]);
      rd_reg(ra[k], re[k]);
    end
    @(posedge clk);
    #1 chk("rdata idle", rdata, 0);
    for (int c = 0; c < 3; c++) begin
      wr_reg(OFS_CONTROL, {8'h00, cv[c]});
      oe <= 1;
      sel <= 1;
      for (int k = 0; k < 16; k++) begin
        @(posedge clk);
        #1 chk("bus", bus, exp_bus(k % 8, cv[c]));
      end
      chk("active", act, 1);
      oe <= 0;
      sel <= 0;
      @(posedge clk);
      #1 chk("off", {act, bus}, 0);
    end
    nrst <= 0;
    repeat (16) @(posedge clk);
    nrst <= 1;
    for (int k = 0; k < 4; k++)
      rd_reg(ra[k], rr[k]);
    oe <= 1;
    @(posedge clk);
    #1 chk("pass", bus, adc);
    @(posedge clk);
    #1 chk("rx", rx, adc);
    print_verdict;
  end
endmodule
`default_nettype wire
